// ### rtl/gsp_core.v
// Gyro serial message slave with command FIFO
`timescale 1ns/10ps
`include "gsp_defines.vh"

// ==========================================================
// Command byte FIFO
module gsp_fifo #(
  parameter W = `GSP_FIFO_WIDTH,
  parameter D = `GSP_FIFO_DEPTH,
  parameter AW = `GSP_FIFO_AW
) (
  input wire mclk,
  input wire rst_n,
  input wire inValid,
  input wire [W-1:0] inData,
  output wire inReady,
  output wire outValid,
  output wire [W-1:0] outData,
  input wire outReady
);
  reg [W-1:0] mem_ff [0:D-1]; // Storage entries
  reg [AW-1:0] wrPtr_ff; // Write index
  reg [AW-1:0] rdPtr_ff; // Read index
  reg [AW:0] count_ff; // Fill level, one bit wider to tell full
  wire doWr = inValid && inReady;
  wire doRd = outValid && outReady;
  assign inReady = (count_ff != D[AW:0]);
  assign outValid = (count_ff != {(AW+1){1'b0}});
  assign outData = mem_ff[rdPtr_ff];

  // Pointers and level
  always @(posedge mclk) begin
    if (!rst_n) begin
      wrPtr_ff <= {AW{1'b0}};
      rdPtr_ff <= {AW{1'b0}};
      count_ff <= {(AW+1){1'b0}};
    end else begin
      if (doWr) begin
        wrPtr_ff <= wrPtr_ff + 1'b1;
      end
      if (doRd) begin
        rdPtr_ff <= rdPtr_ff + 1'b1;
      end
      if (doWr && !doRd) begin
        count_ff <= count_ff + 1'b1;
      end else if (doRd && !doWr) begin
        count_ff <= count_ff - 1'b1;
      end
    end
  end

  // Entry storage, no reset needed for data
  genvar gi;
  generate
    for (gi = 0; gi < D; gi = gi + 1) begin : gEntry
      // Index widened to genvar width, since a genvar has no bit range to select
      always @(posedge mclk) begin
        if (doWr && ({{(32-AW){1'b0}}, wrPtr_ff} == gi)) begin
          mem_ff[gi] <= inData;
        end
      end
    end
  endgenerate
endmodule // gsp_fifo

// ==========================================================
// Top: serial slave, command decode, status message build
module gsp_core (
  input wire mclk,
  input wire rst_n,
  input wire sclk,
  input wire ssN,
  input wire mosi,
  output wire miso,
  output wire misoOe,
  input wire healthFail,
  input wire [15:0] rateIn,
  input wire [7:0] tempIn,
  output wire selfTestOn,
  output wire [1:0] rangeCode,
  output wire lastCmdBad
);
  // ==========================================================
  // Pin synchronisers: sclk, select, data in
  wire [2:0] pinIn = {mosi, ssN, sclk};
  reg [2:0] syncA_ff; // First stage, read only by second stage
  reg [2:0] syncB_ff;
  reg [2:0] syncC_ff;
  reg [2:0] stable_ff; // Accepted level once B and C agree
  wire [2:0] chg = ~(syncB_ff ^ syncC_ff) & (syncC_ff ^ stable_ff);
  genvar gp;
  generate
    for (gp = 0; gp < 3; gp = gp + 1) begin : gSync
      always @(posedge mclk) begin
        if (!rst_n) begin
          // Every stage starts at the pin's idle level, so leaving reset
          // never shows a false select edge that would open a phantom frame
          syncA_ff[gp] <= (gp == 1);
          syncB_ff[gp] <= (gp == 1);
          syncC_ff[gp] <= (gp == 1);
          stable_ff[gp] <= (gp == 1); // Select idles high
        end else begin
          syncA_ff[gp] <= pinIn[gp];
          syncB_ff[gp] <= syncA_ff[gp];
          syncC_ff[gp] <= syncB_ff[gp];
          if (chg[gp]) begin
            stable_ff[gp] <= syncC_ff[gp];
          end
        end
      end
    end
  endgenerate
  wire selActive = !stable_ff[1];
  wire sclkRise = chg[0] && syncC_ff[0] && selActive;
  wire sclkFall = chg[0] && !syncC_ff[0] && selActive;
  wire selFall = chg[1] && !syncC_ff[1];
  wire selRise = chg[1] && syncC_ff[1];
  wire dataBit = stable_ff[2] ^ chg[2]; // Newest agreed data level

  // ==========================================================
  // Receive shifter feeding the FIFO
  reg [7:0] rxShift_ff; // Incoming bits, MSB first
  reg [2:0] bitCnt_ff; // Bit within current byte
  reg overrun_ff; // FIFO was full during this frame
  wire [7:0] rxByte = {rxShift_ff[6:0], dataBit};
  wire byteDone = sclkRise && (bitCnt_ff == 3'h7);
  wire fifoInValid = byteDone || selRise; // Marker closes each frame
  wire [8:0] fifoInData = selRise ? 9'h100 : {1'b0, rxByte};
  wire fifoInReady;
  wire fifoOutValid;
  wire [8:0] fifoOutData;
  reg applyPend_ff; // Verdict waiting to be applied
  wire fifoOutReady = !applyPend_ff; // Drain stalls on the apply cycle

  // Shift bits and count them; a new frame restarts the count
  always @(posedge mclk) begin
    if (!rst_n) begin
      rxShift_ff <= 8'h00;
      bitCnt_ff <= 3'h0;
      overrun_ff <= 1'b0;
    end else begin
      if (selFall) begin
        bitCnt_ff <= 3'h0;
        overrun_ff <= 1'b0;
      end else if (sclkRise) begin
        rxShift_ff <= rxByte;
        bitCnt_ff <= bitCnt_ff + 1'b1;
      end
      // Lost bytes cannot be told apart, so the whole frame fails
      if (fifoInValid && !fifoInReady) begin
        overrun_ff <= 1'b1;
      end
    end
  end

  gsp_fifo #(
    .W(`GSP_FIFO_WIDTH),
    .D(`GSP_FIFO_DEPTH),
    .AW(`GSP_FIFO_AW)
  ) uFifo (
    .mclk(mclk),
    .rst_n(rst_n),
    .inValid(fifoInValid),
    .inData(fifoInData),
    .inReady(fifoInReady),
    .outValid(fifoOutValid),
    .outData(fifoOutData),
    .outReady(fifoOutReady)
  );

  // ==========================================================
  // Command assembly and checking
  reg [2:0] byteCnt_ff; // Bytes seen in the frame, saturates
  reg [7:0] cmdByte_ff; // First byte held for decode
  reg [7:0] sum_ff; // Running sum of bytes 1 to 5
  reg [7:0] chkByte_ff; // Sixth byte as received
  reg pendGood_ff; // Verdict of the closed frame
  reg [7:0] pendCmd_ff;
  reg stOn_ff; // Applied self-test enable
  reg [1:0] range_ff; // Applied range code
  reg bad_ff; // Previous command was rejected
  wire popByte = fifoOutValid && fifoOutReady && !fifoOutData[8];
  wire popMark = fifoOutValid && fifoOutReady && fifoOutData[8];
  wire cmdGood = (byteCnt_ff == `GSP_MSG_BYTES) && !overrun_ff
    && (chkByte_ff == ~sum_ff);

  // Gather bytes; only the first byte, the sum and the sixth byte matter
  always @(posedge mclk) begin
    if (!rst_n) begin
      byteCnt_ff <= 3'h0;
      cmdByte_ff <= 8'h00;
      sum_ff <= 8'h00;
      chkByte_ff <= 8'h00;
      applyPend_ff <= 1'b0;
      pendGood_ff <= 1'b0;
      pendCmd_ff <= 8'h00;
    end else begin
      applyPend_ff <= popMark;
      if (popMark) begin
        pendGood_ff <= cmdGood;
        pendCmd_ff <= cmdByte_ff;
        byteCnt_ff <= 3'h0;
        sum_ff <= 8'h00;
      end else if (popByte) begin
        // Extra bytes beyond six saturate the count and fail the frame
        if (byteCnt_ff != 3'h7) begin
          byteCnt_ff <= byteCnt_ff + 1'b1;
        end
        if (byteCnt_ff == 3'h0) begin
          cmdByte_ff <= fifoOutData[7:0];
        end
        if (byteCnt_ff < `GSP_LAST_BYTE) begin
          sum_ff <= sum_ff + fifoOutData[7:0];
        end
        if (byteCnt_ff == `GSP_LAST_BYTE) begin
          chkByte_ff <= fifoOutData[7:0];
        end
      end
    end
  end

  // Apply settings only after the frame has closed
  always @(posedge mclk) begin
    if (!rst_n) begin
      stOn_ff <= 1'b0;
      range_ff <= `GSP_RNG_DEFAULT;
      bad_ff <= 1'b0;
    end else if (applyPend_ff) begin
      bad_ff <= !pendGood_ff;
      if (pendGood_ff) begin
        // Bits 2:0 and bit 7 take no part in decode
        stOn_ff <= pendCmd_ff[`GSP_CMD_ST_BIT];
        if (pendCmd_ff[`GSP_CMD_RSRC_BIT]) begin
          range_ff <= pendCmd_ff[`GSP_CMD_RNG_HI:`GSP_CMD_RNG_LO];
        end else begin
          range_ff <= `GSP_RNG_DEFAULT;
        end
      end
    end
  end

  // ==========================================================
  // Rate and temperature words
  reg [4:0] rateMul; // Counts per 1/8 deg/s of input
  always @* begin
    case (range_ff)
      `GSP_RNG_900: rateMul = `GSP_MUL_900;
      `GSP_RNG_300: rateMul = `GSP_MUL_300;
      `GSP_RNG_150: rateMul = `GSP_MUL_150;
      default: rateMul = `GSP_MUL_75;
    endcase
  end
  // Self-test adds 50 deg/s before scaling, so it tracks the range
  wire signed [16:0] rateAdj = $signed({rateIn[15], rateIn})
    + $signed(stOn_ff ? `GSP_ST_OFFSET : 17'h00000);
  wire signed [21:0] rateProd = rateAdj * $signed(rateMul);
  wire rateFits = (rateProd[21:15] == {7{rateProd[15]}});
  wire [15:0] rateWord = rateFits ? rateProd[15:0]
    : (rateProd[21] ? `GSP_RATE_MIN : `GSP_RATE_MAX);
  wire signed [12:0] tempProd = $signed(tempIn) * $signed(`GSP_TEMP_MUL);
  wire [15:0] tempWord = `GSP_TEMP_ZERO
    + {{5{tempProd[12]}}, tempProd[12:2]};

  // ==========================================================
  // Status message assembly
  wire [7:0] statByte = {healthFail || stOn_ff, `GSP_MSG_TYPE,
    bad_ff, stOn_ff, 1'b0, range_ff};
  wire [7:0] statSum = statByte + rateWord[15:8] + rateWord[7:0]
    + tempWord[15:8] + tempWord[7:0];
  wire [47:0] statMsg = {statByte, rateWord, tempWord, ~statSum};

  // ==========================================================
  // Transmit shifter: mode 0, next bit placed on falling clock
  reg [47:0] txShift_ff; // Snapshot taken as select falls
  reg miso_ff;
  reg misoOe_ff;
  always @(posedge mclk) begin
    if (!rst_n) begin
      txShift_ff <= 48'h000000000000;
      miso_ff <= 1'b0;
      misoOe_ff <= 1'b0;
    end else begin
      misoOe_ff <= selActive && !selRise;
      if (selFall) begin
        txShift_ff <= {statMsg[46:0], 1'b0};
        miso_ff <= statMsg[47];
        misoOe_ff <= 1'b1;
      end else if (sclkFall) begin
        txShift_ff <= {txShift_ff[46:0], 1'b0};
        miso_ff <= txShift_ff[47];
      end
    end
  end

  // ==========================================================
  // Status ports mirror the applied state
  assign miso = miso_ff;
  assign misoOe = misoOe_ff;
  assign selfTestOn = stOn_ff;
  assign rangeCode = range_ff;
  assign lastCmdBad = bad_ff;
endmodule // gsp_core

// ### rtl/gsp_defines.vh
// Constants for the gyro serial message block
`ifndef GSP_DEFINES_VH
`define GSP_DEFINES_VH
// ==========================================================
// Message framing
`define GSP_MSG_BYTES 3'h6
`define GSP_LAST_BYTE 3'h5
`define GSP_FIFO_WIDTH 9
`define GSP_FIFO_DEPTH 16
`define GSP_FIFO_AW 4
// ==========================================================
// Command byte fields
`define GSP_CMD_ST_BIT 6
`define GSP_CMD_RSRC_BIT 5
`define GSP_CMD_RNG_HI 4
`define GSP_CMD_RNG_LO 3
// ==========================================================
// Range codes, reset range and message type
`define GSP_RNG_900 2'h0
`define GSP_RNG_300 2'h1
`define GSP_RNG_150 2'h2
`define GSP_RNG_75 2'h3
`define GSP_RNG_DEFAULT 2'h3
`define GSP_MSG_TYPE 2'h0
// ==========================================================
// Scaling: rate input is in 1/8 deg/s, multipliers give 8/24/48/96
`define GSP_MUL_900 5'h01
`define GSP_MUL_300 5'h03
`define GSP_MUL_150 5'h06
`define GSP_MUL_75 5'h0c
`define GSP_ST_OFFSET 17'h00190
`define GSP_TEMP_ZERO 16'h0200
`define GSP_TEMP_MUL 5'h0b
`define GSP_RATE_MAX 16'h7fff
`define GSP_RATE_MIN 16'h8000
`endif

// ### tb/gsp_host.sv
// Host model: serial master in mode 0
`timescale 1ns/10ps
module gsp_host (
  input wire mclk,
  output reg sclk,
  output reg ssN,
  output reg mosi,
  input wire miso,
  input wire misoOe
);
  // Idle: select high, clock low
  initial begin
    sclk = 1'b0;
    ssN = 1'b1;
    mosi = 1'b0;
  end
  // ==========
  // One frame of n bits, MSB first; 80 ns link clock
  task xfer(input [47:0] cmd, input integer n, output [47:0] rsp);
    integer i;
    begin
      rsp = 48'h0;
      @(posedge mclk) ssN <= 1'b0;
      repeat (8) @(posedge mclk);
      for (i = 47; i > 47 - n; i = i - 1) begin
        mosi <= cmd[i];
        repeat (4) @(posedge mclk);
        sclk <= 1'b1;
        repeat (4) @(posedge mclk);
        // Late sample: the slave's bit lags the falling edge by its sync chain
        rsp[i] = misoOe & miso;
        sclk <= 1'b0;
      end
      repeat (4) @(posedge mclk);
      ssN <= 1'b1;
      repeat (40) @(posedge mclk);
    end
  endtask
endmodule // gsp_host

// ### tb/gsp_props.sv
// Checker of link timing and applied settings for the gyro slave
`timescale 1ns/10ps
module gsp_props (
  input wire mclk,
  input wire rst_n,
  input wire ssN,
  input wire miso,
  input wire misoOe,
  input wire healthFail,
  input wire selfTestOn,
  input wire [1:0] rangeCode,
  input wire lastCmdBad
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // ==========
  // Frame edges
  sequence s_selFall; $fell(ssN); endsequence
  sequence s_selRise; $rose(ssN); endsequence
  property p_oeOn; s_selFall |-> ##[3:8] misoOe; endproperty
  a_oeOn: assert property (p_oeOn) else $error("output not enabled");
  property p_oeDrop; s_selRise |-> ##[3:8] !misoOe; endproperty
  a_oeDrop: assert property (p_oeDrop) else $error("output not released");
  property p_oeIdle; ssN [*8] |-> !misoOe; endproperty
  a_oeIdle: assert property (p_oeIdle) else $error("driving while idle");
  property p_oeStay; misoOe && !ssN |=> misoOe; endproperty
  a_oeStay: assert property (p_oeStay) else $error("output dropped in frame");
  // ==========
  // First status bit is the fail flag
  property p_firstBit; $rose(misoOe) |-> miso == (healthFail | selfTestOn); endproperty
  a_firstBit: assert property (p_firstBit) else $error("bad first bit");
  // ==========
  // Settings move only between frames and only on good frames
  property p_cfgIdle; !$stable({selfTestOn, rangeCode, lastCmdBad}) |-> ssN; endproperty
  a_cfgIdle: assert property (p_cfgIdle) else $error("settings moved in frame");
  property p_stGood; $changed(selfTestOn) |-> !lastCmdBad; endproperty
  a_stGood: assert property (p_stGood) else $error("self-test from bad frame");
  property p_rngGood; $changed(rangeCode) |-> !lastCmdBad; endproperty
  a_rngGood: assert property (p_rngGood) else $error("range from bad frame");
endmodule // gsp_props
bind gsp_core gsp_props gsp_props_inst (.mclk(mclk), .rst_n(rst_n), .ssN(ssN), .miso(miso),
  .misoOe(misoOe), .healthFail(healthFail), .selfTestOn(selfTestOn),
  .rangeCode(rangeCode), .lastCmdBad(lastCmdBad));

// ### tb/tb_top.sv
// Self-checking bench for the gyro serial slave
`timescale 1ns/10ps
module tb_top;
  reg mclk = 1'b0;
  reg rst_n = 1'b0;
  reg healthFail = 1'b0;
  reg [15:0] rateIn = 16'h0000;
  reg [7:0] tempIn = 8'h00;
  wire sclk, ssN, mosi, miso, misoOe, selfTestOn, lastCmdBad;
  wire [1:0] rangeCode;
  integer failures = 0, compares = 0, cycles = 0, i, n;
  reg [47:0] rsp, exp, cmd;
  reg st = 1'b0;
  reg bad = 1'b0;
  reg [1:0] rng = 2'h3;
  // Command bytes 1..5 per frame; frame 3 gets a bad checksum, frame 4 is short
  localparam [319:0] CMDS = {40'h3000000000, 40'h6000000000, 40'h6711223344,
    40'h2800000000, 40'h3800000000, 40'h2800000000, 40'h0800000000, 40'h0000000000};
  always #5 mclk = ~mclk;
  gsp_core gsp_core_inst (.mclk(mclk), .rst_n(rst_n), .sclk(sclk), .ssN(ssN), .mosi(mosi),
    .miso(miso), .misoOe(misoOe), .healthFail(healthFail), .rateIn(rateIn), .tempIn(tempIn),
    .selfTestOn(selfTestOn), .rangeCode(rangeCode), .lastCmdBad(lastCmdBad));
  gsp_host gsp_host_inst (.mclk(mclk), .sclk(sclk), .ssN(ssN), .mosi(mosi), .miso(miso),
    .misoOe(misoOe));
  // ==========
  // Expected values
  function [47:0] mk(input [39:0] b);
    mk = {b, ~(b[39:32] + b[31:24] + b[23:16] + b[15:8] + b[7:0])};
  endfunction
  function [47:0] stat(input s, input [1:0] r, input b);
    integer ri, ti;
    reg [7:0] b1;
    reg [15:0] rw, tw;
    begin
      ri = ($signed(rateIn) + (s ? 400 : 0)) * (r == 2'h0 ? 1 : r == 2'h1 ? 3 : r == 2'h2 ? 6 : 12);
      ti = ($signed(tempIn) * 11) >>> 2;
      rw = (ri > 32767) ? 16'h7fff : (ri < -32768) ? 16'h8000 : ri[15:0];
      tw = 16'h0200 + ti[15:0];
      b1 = {healthFail | s, 2'h0, b, s, 1'b0, r};
      stat = {b1, rw, tw, ~(b1 + rw[15:8] + rw[7:0] + tw[15:8] + tw[7:0])};
    end
  endfunction
  // ==========
  // Compares and closing
  task chkMsg(input [47:0] got, input [47:0] want);
    begin
      compares = compares + 1;
      if (got !== want) begin
        failures = failures + 1;
        $display("ERROR t=%0t got=%h exp=%h", $time, got, want);
      end
    end
  endtask
  task chkCfg(input [3:0] got, input [3:0] want);
    begin
      compares = compares + 1;
      if (got !== want) begin
        failures = failures + 1;
        $display("ERROR t=%0t got=%h exp=%h", $time, got, want);
      end
    end
  endtask
  task conclude;
    begin
      $display("compares=%0d failures=%0d", compares, failures);
      if (failures == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  // Hang guard: eight frames need about 3450 cycles
  always @(posedge mclk) begin
    cycles = cycles + 1;
    if (cycles == 10000) begin
      failures = failures + 1;
      conclude;
    end
  end
  // ==========
  // Main sequence: each reply shows the settings left by the frame before
  initial begin
    repeat (12) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (2) @(posedge mclk);
    chkCfg({selfTestOn, rangeCode, lastCmdBad}, 4'h6);
    for (i = 0; i < 8; i = i + 1) begin
      cmd = mk(CMDS[319 - 40 * i -: 40]);
      if (i == 3) cmd = cmd ^ 48'h1;
      n = (i == 4) ? 40 : 48;
      healthFail <= (i == 2);
      // Frame 6 drives a rate beyond full scale to reach the clamp
      rateIn <= (i == 6) ? 16'h7000 : 16'hff00 + 16'(i * 48);
      tempIn <= 8'hd8 + 8'(i * 21);
      @(posedge mclk);
      exp = stat(st, rng, bad);
      gsp_host_inst.xfer(cmd, n, rsp);
      chkMsg(rsp, exp & (~48'h0 << (48 - n)));
      if (n == 48 && mk(cmd[47:8]) === cmd) begin
        st = cmd[46];
        rng = cmd[45] ? cmd[44:43] : 2'h3;
        bad = 1'b0;
      end else bad = 1'b1;
      chkCfg({selfTestOn, rangeCode, lastCmdBad}, {st, rng, bad});
    end
    conclude;
  end
endmodule // tb_top
